// *** rtl/bst_pkg.sv ***
// Constants and types shared by the boundary-scan test port files.
package bst_pkg;
  localparam int IR_W = 5;
  localparam int NUM_IO = 8;
  localparam int CELLS_PER_IO = 3;
  localparam int BSR_W = NUM_IO * CELLS_PER_IO;
  localparam int ID_W = 32;
  localparam int CELL_IN = 0;
  localparam int CELL_OUT = 1;
  localparam int CELL_OE = 2;

  // Instruction codes.
  localparam logic [IR_W-1:0] INS_EXTEST = 5'h00;
  localparam logic [IR_W-1:0] INS_SAMPLE = 5'h01;
  localparam logic [IR_W-1:0] INS_USER_CHAIN_ONE = 5'h02;
  localparam logic [IR_W-1:0] INS_USER_CHAIN_TWO = 5'h03;
  localparam logic [IR_W-1:0] INS_CFG_READ = 5'h04;
  localparam logic [IR_W-1:0] INS_CFG_WRITE = 5'h05;
  localparam logic [IR_W-1:0] INS_DESIGN_CODE_SHIFT = 5'h08;
  localparam logic [IR_W-1:0] INS_IDENT = 5'h09;
  localparam logic [IR_W-1:0] INS_OUTPUTS_FLOAT_BYPASS = 5'h0a;
  localparam logic [IR_W-1:0] INS_CFG_BUS_RESET = 5'h0b;
  localparam logic [IR_W-1:0] INS_STARTUP_STEP = 5'h0c;
  localparam logic [IR_W-1:0] INS_BYPASS = 5'h1f;

  // Fixed pattern loaded into the instruction register on Capture-IR.
  localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 5'h01;
  // Identification value; arbitrary neutral value.
  localparam logic [ID_W-1:0] IDENT_VAL = 32'h0000_0a5b;

  typedef enum logic [3:0] {
    ST_TLR = 4'h0,
    ST_RTI = 4'h1,
    ST_SEL_DR = 4'h2,
    ST_CAP_DR = 4'h3,
    ST_SH_DR = 4'h4,
    ST_EX1_DR = 4'h5,
    ST_PA_DR = 4'h6,
    ST_EX2_DR = 4'h7,
    ST_UPD_DR = 4'h8,
    ST_SEL_IR = 4'h9,
    ST_CAP_IR = 4'ha,
    ST_SH_IR = 4'hb,
    ST_EX1_IR = 4'hc,
    ST_PA_IR = 4'hd,
    ST_EX2_IR = 4'he,
    ST_UPD_IR = 4'hf
  } bst_state_type;
endpackage

// *** rtl/bst_shift_reg.sv ***
// Capture-and-shift scan register, shifting from the top toward bit zero.
module bst_shift_reg #(
  parameter int WIDTH = 1
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_capture,
  input wire logic i_shift,
  input wire logic [WIDTH-1:0] i_cap_val,
  input wire logic i_sdi,
  output logic [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] q_r;
  logic [WIDTH-1:0] q_nxt;
  logic [WIDTH:0] shifted;

  assign shifted = {i_sdi, q_r};
  assign q_nxt = i_capture ? i_cap_val :
                 i_shift ? shifted[WIDTH:1] : q_r;
  assign o_q = q_r;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end
endmodule

// *** rtl/bst_tap.sv ***
// Boundary-scan test access port with instruction decode and scan chains.
module bst_tap (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  output logic o_tdo,
  output logic o_tdo_oe,
  input wire logic [bst_pkg::NUM_IO-1:0] i_pad_in,
  output logic [bst_pkg::NUM_IO-1:0] o_pad_out,
  output logic [bst_pkg::NUM_IO-1:0] o_pad_oe,
  input wire logic [bst_pkg::NUM_IO-1:0] i_core_out,
  input wire logic [bst_pkg::NUM_IO-1:0] i_core_oe,
  output logic [bst_pkg::NUM_IO-1:0] o_core_in,
  input wire logic i_cfg_done,
  input wire logic [bst_pkg::ID_W-1:0] i_design_code,
  input wire logic i_cfg_tdo,
  input wire logic i_startup_clock_source,
  input wire logic i_user_tdo_one,
  input wire logic i_user_tdo_two,
  output logic o_user_chain_one,
  output logic o_user_chain_two,
  output logic o_user_reset,
  output logic o_user_update,
  output logic o_user_shift,
  output logic o_scan_step,
  output logic o_scan_tdi,
  output logic o_cfg_read_sel,
  output logic o_cfg_write_sel,
  output logic o_cfg_bus_reset,
  output logic o_startup_step
);
  localparam int NIO = bst_pkg::NUM_IO;
  localparam int CW = bst_pkg::CELLS_PER_IO;

  // Pin synchronisers; first stages are read only by the second.
  logic tck_s1_r, tck_s2_r, tck_d_r;
  logic tms_s1_r, tms_s2_r;
  logic tdi_s1_r, tdi_s2_r;
  logic [NIO-1:0] pad_s1_r, pad_s2_r;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tck_s1_r <= 1'b0;
      tck_s2_r <= 1'b0;
      tck_d_r <= 1'b0;
      tms_s1_r <= 1'b1;
      tms_s2_r <= 1'b1;
      tdi_s1_r <= 1'b0;
      tdi_s2_r <= 1'b0;
      pad_s1_r <= '0;
      pad_s2_r <= '0;
    end else begin
      tck_s1_r <= i_tck;
      tck_s2_r <= tck_s1_r;
      tck_d_r <= tck_s2_r;
      tms_s1_r <= i_tms;
      tms_s2_r <= tms_s1_r;
      tdi_s1_r <= i_tdi;
      tdi_s2_r <= tdi_s1_r;
      pad_s1_r <= i_pad_in;
      pad_s2_r <= pad_s1_r;
    end
  end

  wire tck_rise = tck_s2_r & ~tck_d_r;
  wire tck_fall = ~tck_s2_r & tck_d_r;

  // Port state machine, advanced on each test clock rising edge.
  bst_pkg::bst_state_type state_r, state_nxt, st_step;

  always_comb begin
    unique case (state_r)
      bst_pkg::ST_TLR: st_step = tms_s2_r ? bst_pkg::ST_TLR : bst_pkg::ST_RTI;
      bst_pkg::ST_RTI: st_step = tms_s2_r ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
      bst_pkg::ST_SEL_DR: st_step = tms_s2_r ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
      bst_pkg::ST_CAP_DR: st_step = tms_s2_r ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_SH_DR: st_step = tms_s2_r ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_EX1_DR: st_step = tms_s2_r ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PA_DR;
      bst_pkg::ST_PA_DR: st_step = tms_s2_r ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PA_DR;
      bst_pkg::ST_EX2_DR: st_step = tms_s2_r ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_UPD_DR: st_step = tms_s2_r ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
      bst_pkg::ST_SEL_IR: st_step = tms_s2_r ? bst_pkg::ST_TLR : bst_pkg::ST_CAP_IR;
      bst_pkg::ST_CAP_IR: st_step = tms_s2_r ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_SH_IR: st_step = tms_s2_r ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_EX1_IR: st_step = tms_s2_r ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PA_IR;
      bst_pkg::ST_PA_IR: st_step = tms_s2_r ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PA_IR;
      bst_pkg::ST_EX2_IR: st_step = tms_s2_r ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_UPD_IR: st_step = tms_s2_r ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
    endcase
  end

  assign state_nxt = tck_rise ? st_step : state_r;

  wire in_cap_dr = (state_r == bst_pkg::ST_CAP_DR);
  wire in_sh_dr = (state_r == bst_pkg::ST_SH_DR);
  wire in_cap_ir = (state_r == bst_pkg::ST_CAP_IR);
  wire in_sh_ir = (state_r == bst_pkg::ST_SH_IR);
  wire cap_dr = tck_rise & in_cap_dr;
  wire sh_dr = tck_rise & in_sh_dr;
  wire upd_dr = tck_fall & (state_r == bst_pkg::ST_UPD_DR);
  wire upd_ir = tck_fall & (state_r == bst_pkg::ST_UPD_IR);
  wire in_tlr = (state_r == bst_pkg::ST_TLR);

  // Instruction register: shift stage and active stage.
  logic [bst_pkg::IR_W-1:0] ir_q;
  logic [bst_pkg::IR_W-1:0] ins_r, ins_nxt;

  bst_shift_reg #(.WIDTH(bst_pkg::IR_W)) u_ir (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_capture(tck_rise & in_cap_ir),
    .i_shift(tck_rise & in_sh_ir),
    .i_cap_val(bst_pkg::IR_CAPTURE_VAL),
    .i_sdi(tdi_s2_r),
    .o_q(ir_q)
  );

  assign ins_nxt = in_tlr ? bst_pkg::INS_IDENT :
                   upd_ir ? ir_q : ins_r;

  // Instruction decode; user instructions need a loaded configuration.
  wire d_extest = (ins_r == bst_pkg::INS_EXTEST);
  wire d_sample = (ins_r == bst_pkg::INS_SAMPLE);
  wire d_user1 = (ins_r == bst_pkg::INS_USER_CHAIN_ONE) & i_cfg_done;
  wire d_user2 = (ins_r == bst_pkg::INS_USER_CHAIN_TWO) & i_cfg_done;
  wire d_cfg_rd = (ins_r == bst_pkg::INS_CFG_READ);
  wire d_cfg_wr = (ins_r == bst_pkg::INS_CFG_WRITE);
  wire d_dcode = (ins_r == bst_pkg::INS_DESIGN_CODE_SHIFT) & i_cfg_done;
  wire d_ident = (ins_r == bst_pkg::INS_IDENT);
  wire d_float = (ins_r == bst_pkg::INS_OUTPUTS_FLOAT_BYPASS);
  wire d_busrst = (ins_r == bst_pkg::INS_CFG_BUS_RESET);
  wire d_start = (ins_r == bst_pkg::INS_STARTUP_STEP);
  wire d_bsr = d_extest | d_sample;
  wire d_cfg_any = d_cfg_rd | d_cfg_wr;
  wire d_other = d_bsr | d_user1 | d_user2 | d_cfg_any | d_dcode | d_ident;
  wire d_bypass = ~d_other;

  // Boundary chain: input, output and enable cell for each I/O.
  logic [bst_pkg::BSR_W-1:0] bsr_cap, bsr_q;
  logic [bst_pkg::BSR_W-1:0] bsr_upd_r, bsr_upd_nxt;

  for (genvar g = 0; g < NIO; g++) begin : g_cell
    assign bsr_cap[g*CW+bst_pkg::CELL_IN] = pad_s2_r[g];
    assign bsr_cap[g*CW+bst_pkg::CELL_OUT] = i_core_out[g];
    assign bsr_cap[g*CW+bst_pkg::CELL_OE] = i_core_oe[g];
  end

  bst_shift_reg #(.WIDTH(bst_pkg::BSR_W)) u_bsr (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_capture(cap_dr & d_bsr),
    .i_shift(sh_dr & d_bsr),
    .i_cap_val(bsr_cap),
    .i_sdi(tdi_s2_r),
    .o_q(bsr_q)
  );

  assign bsr_upd_nxt = (upd_dr & d_bsr) ? bsr_q : bsr_upd_r;

  // Identification and design code registers.
  logic [bst_pkg::ID_W-1:0] id_q, dc_q;

  bst_shift_reg #(.WIDTH(bst_pkg::ID_W)) u_id (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_capture(cap_dr & d_ident),
    .i_shift(sh_dr & d_ident),
    .i_cap_val(bst_pkg::IDENT_VAL),
    .i_sdi(tdi_s2_r),
    .o_q(id_q)
  );

  bst_shift_reg #(.WIDTH(bst_pkg::ID_W)) u_dc (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_capture(cap_dr & d_dcode),
    .i_shift(sh_dr & d_dcode),
    .i_cap_val(i_design_code),
    .i_sdi(tdi_s2_r),
    .o_q(dc_q)
  );

  logic byp_q;

  bst_shift_reg #(.WIDTH(1)) u_byp (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_capture(cap_dr & d_bypass),
    .i_shift(sh_dr & d_bypass),
    .i_cap_val(1'b0),
    .i_sdi(tdi_s2_r),
    .o_q(byp_q)
  );

  // Data path selection toward test data out.
  wire dr_out = d_bsr ? bsr_q[0] :
                d_user1 ? i_user_tdo_one :
                d_user2 ? i_user_tdo_two :
                d_cfg_any ? i_cfg_tdo :
                d_dcode ? dc_q[0] :
                d_ident ? id_q[0] : byp_q;
  wire tdo_sel = in_sh_ir ? ir_q[0] : dr_out;
  wire tdo_en = in_sh_ir | in_sh_dr;

  // Test data out changes on the falling test clock edge.
  wire tdo_nxt = tck_fall ? tdo_sel : o_tdo;
  wire tdo_oe_nxt = tck_fall ? tdo_en : o_tdo_oe;

  // Pad drive: test values under external test, floated, or core values.
  wire [NIO-1:0] upd_out, upd_oe;
  for (genvar g = 0; g < NIO; g++) begin : g_pad
    assign upd_out[g] = bsr_upd_r[g*CW+bst_pkg::CELL_OUT];
    assign upd_oe[g] = bsr_upd_r[g*CW+bst_pkg::CELL_OE];
  end
  wire [NIO-1:0] pad_out_nxt = d_extest ? upd_out : i_core_out;
  wire [NIO-1:0] pad_oe_nxt = d_float ? '0 :
                              d_extest ? upd_oe : i_core_oe;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= bst_pkg::ST_TLR;
      ins_r <= bst_pkg::INS_IDENT;
      bsr_upd_r <= '0;
      o_tdo <= 1'b0;
      o_tdo_oe <= 1'b0;
      o_pad_out <= '0;
      o_pad_oe <= '0;
      o_core_in <= '0;
      o_user_chain_one <= 1'b0;
      o_user_chain_two <= 1'b0;
      o_user_reset <= 1'b1;
      o_user_update <= 1'b0;
      o_user_shift <= 1'b0;
      o_scan_step <= 1'b0;
      o_scan_tdi <= 1'b0;
      o_cfg_read_sel <= 1'b0;
      o_cfg_write_sel <= 1'b0;
      o_cfg_bus_reset <= 1'b0;
      o_startup_step <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ins_r <= ins_nxt;
      bsr_upd_r <= bsr_upd_nxt;
      o_tdo <= tdo_nxt;
      o_tdo_oe <= tdo_oe_nxt;
      o_pad_out <= pad_out_nxt;
      o_pad_oe <= pad_oe_nxt;
      o_core_in <= pad_s2_r;
      o_user_chain_one <= d_user1;
      o_user_chain_two <= d_user2;
      o_user_reset <= in_tlr;
      o_user_update <= (state_r == bst_pkg::ST_UPD_DR);
      o_user_shift <= in_sh_dr;
      o_scan_step <= sh_dr;
      o_scan_tdi <= tdi_s2_r;
      o_cfg_read_sel <= d_cfg_rd;
      o_cfg_write_sel <= d_cfg_wr;
      o_cfg_bus_reset <= d_busrst;
      o_startup_step <= tck_rise & d_start & i_startup_clock_source & 
                        (state_r == bst_pkg::ST_RTI);
    end
  end
endmodule

// *** dv/bst_tap_chk.sv ***
// Concurrent checks on the test port outputs, bound to the top module.
module bst_tap_chk (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_tck,
  input wire logic i_cfg_done,
  input wire logic i_startup_clock_source,
  input wire logic o_tdo,
  input wire logic o_tdo_oe,
  input wire logic o_user_chain_one,
  input wire logic o_user_chain_two,
  input wire logic o_user_reset,
  input wire logic o_user_update,
  input wire logic o_user_shift,
  input wire logic o_scan_step,
  input wire logic o_cfg_read_sel,
  input wire logic o_cfg_write_sel,
  input wire logic o_cfg_bus_reset,
  input wire logic o_startup_step
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);
  a_path_one_hot: assert property ($onehot0({o_user_chain_one,
    o_user_chain_two, o_cfg_read_sel, o_cfg_write_sel, o_cfg_bus_reset}))
    else $error("two scan paths selected at once");
  a_user_needs_cfg: assert property (
    $rose(o_user_chain_one) || $rose(o_user_chain_two) |-> $past(i_cfg_done))
    else $error("user chain selected while unconfigured");
  a_state_one_hot: assert property (
    $onehot0({o_user_reset, o_user_update, o_user_shift}))
    else $error("two port states shown at once");
  a_step_source: assert property (o_startup_step |->
    i_startup_clock_source && $past(i_startup_clock_source))
    else $error("startup stepped without test clock source");
  a_step_pulse: assert property (o_startup_step |=> !o_startup_step)
    else $error("startup step longer than one cycle");
  a_scan_pulse: assert property (o_scan_step |=> !o_scan_step)
    else $error("scan step longer than one cycle");
  a_scan_in_shift: assert property (
    o_scan_step |-> o_user_shift || $past(o_user_shift))
    else $error("scan step outside the shift state");
  a_tdo_at_fall: assert property ($changed(o_tdo) |->
    !$past(i_tck) && !$past(i_tck, 2))
    else $error("test data out moved away from a falling edge");
  a_tdo_oe_at_fall: assert property ($changed(o_tdo_oe) |->
    !$past(i_tck) && !$past(i_tck, 2))
    else $error("data out enable moved away from a falling edge");
  c_startup: cover property (o_startup_step);
  c_user_one: cover property (o_user_chain_one);
  c_bus_reset: cover property (o_cfg_bus_reset);
endmodule

bind bst_tap bst_tap_chk i_bst_tap_chk (.i_mclk, .i_rst_n, .i_tck,
  .i_cfg_done, .i_startup_clock_source, .o_tdo, .o_tdo_oe,
  .o_user_chain_one, .o_user_chain_two, .o_user_reset, .o_user_update,
  .o_user_shift, .o_scan_step, .o_cfg_read_sel, .o_cfg_write_sel,
  .o_cfg_bus_reset, .o_startup_step);

// *** dv/bst_ctrl_model.sv ***
// Model of the external test controller that drives the scan pins.
module bst_ctrl_model (
  input wire logic i_mclk,
  input wire logic i_tdo,
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  // The clock stands low between calls; data out is read before each fall.
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    repeat (4) @(posedge i_mclk);
    #1 o_tck = 1'b1;
    repeat (4) @(posedge i_mclk);
    #1 tdo = i_tdo;
    o_tck = 1'b0;
  endtask
  // Data in is not meaningful here, so it is inverted each step.
  task automatic nav(input logic tms);
    logic t;
    step(tms, ~o_tdi, t);
  endtask
  task automatic reset_tap();
    repeat (5) nav(1'b1);
  endtask
  task automatic load_ir(input logic [4:0] code);
    logic t;
    for (int i = 0; i < 4; i++) nav(i < 2);
    for (int i = 0; i < 5; i++) step(i == 4, code[i], t);
    nav(1'b1);
    nav(1'b0);
  endtask
  task automatic scan_dr(input int n, input logic [31:0] din,
    output logic [31:0] dout);
    dout = '0;
    for (int i = 0; i < 3; i++) nav(i == 0);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    nav(1'b1);
    nav(1'b0);
  endtask
endmodule

// *** dv/bst_tap_bench.sv ***
// Self-checking bench of the boundary-scan test port.
module bst_tap_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] PAT = 32'hc3a5_96e1;
  localparam logic [31:0] DCODE = 32'h1234_5678;
  logic i_mclk, i_rst_n, tck, tms, tdi, tdo, tdo_oe, cfg_done, src, rcfg;
  logic user_reset, user_update, user_shift, scan_step, startup_step;
  logic ctdo, utdo1, utdo2, scan_tdi, upd_d, sh_d;
  logic [7:0] pad_in, core_out, core_oe, pad_out, pad_oe, core_in;
  logic [4:0] code, esel;
  wire logic [4:0] sel;
  logic [1:0] kind;
  logic [31:0] dout, expv, dcode, tdi_log;
  logic [44:0] rows [16];
  int errors, checked, n_start, n_scan, n_upd, n_sh;
  // Data out floats high when not driven.
  wire logic tdo_w = tdo_oe ? tdo : 1'b1;
  bst_tap i_bst_tap (.i_mclk, .i_rst_n, .i_tck(tck), .i_tms(tms),
    .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_pad_in(pad_in),
    .o_pad_out(pad_out), .o_pad_oe(pad_oe), .i_core_out(core_out),
    .i_core_oe(core_oe), .o_core_in(core_in), .i_cfg_done(cfg_done),
    .i_design_code(dcode), .i_cfg_tdo(ctdo), .i_startup_clock_source(src),
    .i_user_tdo_one(utdo1), .i_user_tdo_two(utdo2),
    .o_user_chain_one(sel[4]), .o_user_chain_two(sel[3]),
    .o_user_reset(user_reset), .o_user_update(user_update),
    .o_user_shift(user_shift), .o_scan_step(scan_step),
    .o_scan_tdi(scan_tdi),
    .o_cfg_read_sel(sel[2]), .o_cfg_write_sel(sel[1]),
    .o_cfg_bus_reset(sel[0]), .o_startup_step(startup_step));
  bst_ctrl_model i_bst_ctrl_model (.i_mclk, .i_tdo(tdo_w), .o_tck(tck),
    .o_tms(tms), .o_tdi(tdi));
  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    if (startup_step === 1'b1) n_start <= n_start + 1;
    if (scan_step === 1'b1) n_scan <= n_scan + 1;
    if (scan_step === 1'b1) tdi_log <= {scan_tdi, tdi_log[31:1]};
    upd_d <= user_update;
    sh_d <= user_shift;
    if (user_update === 1'b1 && upd_d === 1'b0) n_upd <= n_upd + 1;
    if (user_shift === 1'b1 && sh_d === 1'b0) n_sh <= n_sh + 1;
  end
  task automatic cmp(input string name, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic [23:0] cap();
    for (int i = 0; i < 8; i++) begin
      cap[3*i] = pad_in[i];
      cap[3*i+1] = core_out[i];
      cap[3*i+2] = core_oe[i];
    end
  endfunction
  initial begin
    #2000000;
    errors++;
    tally_and_finish();
  end
  initial begin
    i_rst_n = 1'b0;
    {pad_in, core_out, core_oe} = 24'h3c_5a_f0;
    {cfg_done, src} = 2'b00;
    {ctdo, utdo1, utdo2} = 3'b110;
    dcode = DCODE;
    rows = '{{5'h01, 1'b1, 5'h00, 2'd3, 32'h0},
      {5'h00, 1'b1, 5'h00, 2'd0, 32'h0},
      {5'h02, 1'b1, 5'h10, 2'd1, 32'hffff_ffff},
      {5'h03, 1'b1, 5'h08, 2'd1, 32'h0},
      {5'h04, 1'b1, 5'h04, 2'd1, 32'hffff_ffff},
      {5'h05, 1'b1, 5'h02, 2'd0, 32'h0}, {5'h08, 1'b1, 5'h00, 2'd1, DCODE},
      {5'h09, 1'b1, 5'h00, 2'd1, bst_pkg::IDENT_VAL},
      {5'h0a, 1'b1, 5'h00, 2'd2, 32'h0}, {5'h0b, 1'b1, 5'h01, 2'd0, 32'h0},
      {5'h0c, 1'b1, 5'h00, 2'd0, 32'h0}, {5'h1f, 1'b1, 5'h00, 2'd2, 32'h0},
      {5'h07, 1'b1, 5'h00, 2'd2, 32'h0}, {5'h1e, 1'b1, 5'h00, 2'd2, 32'h0},
      {5'h02, 1'b0, 5'h00, 2'd2, 32'h0}, {5'h08, 1'b0, 5'h00, 2'd2, 32'h0}};
    repeat (5) @(posedge i_mclk);
    #1;
    cmp("user_reset", 1, 32'(user_reset));
    cmp("tdo_oe", 0, 32'(tdo_oe));
    i_rst_n = 1'b1;
    i_bst_ctrl_model.nav(1'b0);
    n_scan = 0;
    n_upd = 0;
    n_sh = 0;
    i_bst_ctrl_model.scan_dr(32, PAT, dout);
    cmp("ident", bst_pkg::IDENT_VAL, dout);
    cmp("scan_steps", 32, n_scan);
    cmp("scan_tdi", PAT, tdi_log);
    cmp("update_entries", 1, n_upd);
    cmp("shift_entries", 1, n_sh);
    for (int k = 0; k < 16; k++) begin
      {code, rcfg, esel, kind, expv} = rows[k];
      cfg_done = rcfg;
      i_bst_ctrl_model.load_ir(code);
      cmp("select", 32'(esel), 32'(sel));
      i_bst_ctrl_model.scan_dr(32, PAT, dout);
      if (kind == 2'd2) expv = {PAT[30:0], 1'b0};
      if (kind == 2'd3) expv = {PAT[7:0], cap()};
      if (kind != 2'd0) cmp("dr_out", expv, dout);
    end
    i_bst_ctrl_model.load_ir(bst_pkg::INS_SAMPLE);
    i_bst_ctrl_model.scan_dr(32, PAT, dout);
    i_bst_ctrl_model.load_ir(bst_pkg::INS_EXTEST);
    for (int i = 0; i < 8; i++) begin
      cmp("pad_out", 32'(PAT[9+3*i]), 32'(pad_out[i]));
      cmp("pad_oe", 32'(PAT[10+3*i]), 32'(pad_oe[i]));
    end
    i_bst_ctrl_model.load_ir(bst_pkg::INS_OUTPUTS_FLOAT_BYPASS);
    cmp("float_oe", 0, 32'(pad_oe));
    i_bst_ctrl_model.load_ir(bst_pkg::INS_BYPASS);
    {pad_in, core_out, core_oe} = 24'h96_69_0f;
    repeat (4) @(posedge i_mclk);
    #1;
    cmp("core_drive", {16'h0, core_oe, core_out}, {16'h0, pad_oe, pad_out});
    cmp("core_in", 32'(pad_in), 32'(core_in));
    src = 1'b1;
    i_bst_ctrl_model.load_ir(bst_pkg::INS_STARTUP_STEP);
    n_start = 0;
    repeat (4) i_bst_ctrl_model.nav(1'b0);
    repeat (2) @(posedge i_mclk);
    #1 src = 1'b0;
    repeat (4) i_bst_ctrl_model.nav(1'b0);
    cmp("startup_steps", 4, n_start);
    i_bst_ctrl_model.reset_tap();
    cmp("tms_reset", 1, 32'(user_reset));
    i_bst_ctrl_model.nav(1'b0);
    i_bst_ctrl_model.scan_dr(32, PAT, dout);
    cmp("ident_again", bst_pkg::IDENT_VAL, dout);
    i_bst_ctrl_model.load_ir(bst_pkg::INS_BYPASS);
    i_rst_n = 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    cmp("mid_reset", 1, 32'(user_reset));
    i_rst_n = 1'b1;
    i_bst_ctrl_model.nav(1'b0);
    i_bst_ctrl_model.scan_dr(32, PAT, dout);
    cmp("ident_after_reset", bst_pkg::IDENT_VAL, dout);
    tally_and_finish();
  end
endmodule
